//--- design/cmd_decoder_regs.svh
// Constants of the status bus command decoder
`ifndef CMD_DECODER_REGS_SVH
`define CMD_DECODER_REGS_SVH

// ==========================================
// Timing
`define CLK_PERIOD_NS 20
`define GRANT_DELAY_NS 115
`define GRANT_DELAY_CYC ((`GRANT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================
// Reset and idle values
`define CMD_IDLE 7'h7f
`define STATUS_RESET 3'h7
// Grant high, qualifier low, strap low until the pins are seen
`define CTRL_RESET 3'h4

`endif

//--- design/cmd_decoder_pkg.sv
// Types shared by the status bus command decoder
package cmd_decoder_pkg;

  // Status codes as seen on the three status pins (bit 2 first)
  typedef enum logic [2:0] {
    ST_INT_ACK = 3'h0,
    ST_IO_READ = 3'h1,
    ST_IO_WRITE = 3'h2,
    ST_HALT = 3'h3,
    ST_CODE = 3'h4,
    ST_MEM_READ = 3'h5,
    ST_MEM_WRITE = 3'h6,
    ST_PASSIVE = 3'h7
  } status_t;

  // Machine cycle phases
  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_CMD, PH_DATA} phase_t;

  // Command strobes, all active low
  typedef struct packed {
    logic mem_read_n;
    logic mem_write_n;
    logic early_mem_write_n;
    logic io_read_n;
    logic io_write_n;
    logic early_io_write_n;
    logic int_ack_n;
  } cmd_t;

endpackage : cmd_decoder_pkg

//--- design/pin_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] sync
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= INIT;
      sync_r <= INIT;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
    end
  end
  assign sync = sync_r;
endmodule : pin_sync

//--- design/grant_timer.sv
// Counts how long the bus grant has been held low
`timescale 1ns/10ps
module grant_timer #(
  parameter int CYCLES = 6
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic grant_n_s,
  output logic ready
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic ready_r;
  logic ready_nxt;

  if (CYCLES < 1 || CYCLES > 255) begin : g_chk
    $error("grant_timer: CYCLES out of range");
  end

  // Count up while granted, restart as soon as the grant drops
  always_comb begin
    cnt_nxt = cnt_r;
    ready_nxt = 1'b0;
    if (grant_n_s) begin
      cnt_nxt = 8'h00;
    end else if (cnt_r < 8'(CYCLES)) begin
      cnt_nxt = cnt_r + 8'h01;
    end
    ready_nxt = !grant_n_s && (cnt_nxt >= 8'(CYCLES));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 8'h00;
      ready_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ready_r <= ready_nxt;
    end
  end
  assign ready = ready_r;

  grant_delay_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(ready_r) |-> cnt_r == 8'(CYCLES))
    else $error("grant ready before delay elapsed");
  grant_drop_a: assert property (@(posedge clk) disable iff (!resetn)
    grant_n_s |=> !ready_r)
    else $error("grant ready kept after grant dropped");
endmodule : grant_timer

//--- design/status_bus_command_decoder.sv
// Status decoder producing command strobes, latch strobe and transceiver controls
`timescale 1ns/10ps
`include "cmd_decoder_regs.svh"
module status_bus_command_decoder
  import cmd_decoder_pkg::*;
#(
  parameter int GRANT_CYCLES = `GRANT_DELAY_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic status_bit_zero_n,
  input wire logic status_bit_one_n,
  input wire logic status_bit_two_n,
  input wire logic bus_grant_n,
  input wire logic cmd_qualify,
  input wire logic io_bus_strap,
  output cmd_t cmd_n,
  output logic mem_cmd_oe,
  output logic io_cmd_oe,
  output logic addr_latch_strobe,
  output logic data_xcvr_enable,
  output logic xfer_direction,
  output logic cascade_periph_xcvr_enable_n
);

  // ==========================================
  // Pin synchronisers
  logic [2:0] status_s;
  logic grant_n_s;
  logic qualify_s;
  logic strap_s;
  logic grant_ready;

  // Status pins, idle value is passive
  pin_sync #(.W(3), .INIT(`STATUS_RESET)) u_status_sync (
    .clk(clk),
    .resetn(resetn),
    .pin({status_bit_two_n, status_bit_one_n, status_bit_zero_n}),
    .sync(status_s)
  );

  // Grant, qualifier and mode strap
  pin_sync #(.W(3), .INIT(`CTRL_RESET)) u_ctrl_sync (
    .clk(clk),
    .resetn(resetn),
    .pin({bus_grant_n, cmd_qualify, io_bus_strap}),
    .sync({grant_n_s, qualify_s, strap_s})
  );

  // Grant must stay low for the delay before memory commands, and I/O commands in system bus mode, are driven
  grant_timer #(.CYCLES(GRANT_CYCLES)) u_grant_timer (
    .clk(clk),
    .resetn(resetn),
    .grant_n_s(grant_n_s),
    .ready(grant_ready)
  );

  // ==========================================
  // Machine cycle sequencer
  phase_t phase_r;
  phase_t phase_nxt;
  status_t code_r;
  status_t code_nxt;
  logic io_mode_r;
  logic io_mode_nxt;
  logic passive_s;
  logic is_write;

  assign passive_s = (status_s == `STATUS_RESET);
  assign is_write = (status_s == ST_IO_WRITE) || (status_s == ST_MEM_WRITE);

  // Start one cycle after a non-passive code, end on passive
  always_comb begin
    phase_nxt = phase_r;
    code_nxt = code_r;
    io_mode_nxt = strap_s;
    unique case (phase_r)
      PH_IDLE: begin
        if (!passive_s) begin
          phase_nxt = PH_ADDR;
          code_nxt = status_t'(status_s);
        end
      end
      PH_ADDR: begin
        phase_nxt = passive_s ? PH_IDLE : PH_CMD;
      end
      PH_CMD: begin
        phase_nxt = passive_s ? PH_IDLE : PH_DATA;
      end
      PH_DATA: begin
        if (passive_s) begin
          phase_nxt = PH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_r <= PH_IDLE;
      code_r <= ST_PASSIVE;
      io_mode_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      code_r <= code_nxt;
      io_mode_r <= io_mode_nxt;
    end
  end

  // ==========================================
  // Command and control generation
  cmd_t cmd_r;
  cmd_t cmd_nxt;
  logic ale_r;
  logic ale_nxt;
  logic den_r;
  logic den_nxt;
  logic dir_r;
  logic dir_nxt;
  logic shared_r;
  logic shared_nxt;
  logic mem_oe_r;
  logic mem_oe_nxt;
  logic io_oe_r;
  logic io_oe_nxt;
  logic live;
  logic early;
  logic late;
  logic mem_ok;
  logic io_ok;
  logic io_cycle;

  // Command phases follow the sequencer next state
  assign live = (phase_nxt == PH_CMD) || (phase_nxt == PH_DATA);
  assign early = live;
  assign late = (phase_nxt == PH_DATA);
  // Memory always waits for grant; I/O only in system bus mode
  assign mem_ok = grant_ready && qualify_s;
  assign io_ok = (io_mode_nxt || grant_ready) && qualify_s;
  assign io_cycle = (code_nxt == ST_IO_READ) || (code_nxt == ST_IO_WRITE)
    || (code_nxt == ST_INT_ACK);

  // Decode the latched code into strobes and controls
  always_comb begin
    cmd_nxt = `CMD_IDLE;
    ale_nxt = (phase_nxt == PH_ADDR);
    dir_nxt = dir_r;
    den_nxt = 1'b0;
    shared_nxt = io_mode_nxt;
    mem_oe_nxt = grant_ready;
    io_oe_nxt = io_mode_nxt || grant_ready;
    if (phase_nxt == PH_ADDR) begin
      dir_nxt = is_write;
      shared_nxt = io_mode_nxt || (status_s == ST_INT_ACK);
    end else if (phase_nxt == PH_IDLE) begin
      dir_nxt = 1'b0;
    end
    if (live) begin
      unique case (code_nxt)
        ST_INT_ACK: cmd_nxt.int_ack_n = !(io_ok && early);
        ST_IO_READ: cmd_nxt.io_read_n = !(io_ok && early);
        ST_IO_WRITE: begin
          cmd_nxt.early_io_write_n = !(io_ok && early);
          cmd_nxt.io_write_n = !(io_ok && late);
        end
        ST_CODE, ST_MEM_READ: cmd_nxt.mem_read_n = !(mem_ok && early);
        ST_MEM_WRITE: begin
          cmd_nxt.early_mem_write_n = !(mem_ok && early);
          cmd_nxt.mem_write_n = !(mem_ok && late);
        end
        ST_HALT, ST_PASSIVE: cmd_nxt = `CMD_IDLE;
      endcase
      if (code_nxt != ST_HALT && code_nxt != ST_PASSIVE) begin
        // In I/O bus mode the peripheral enable serves I/O cycles
        if (io_mode_nxt && io_cycle) begin
          shared_nxt = !(qualify_s && io_ok);
        end else begin
          den_nxt = (io_cycle ? io_ok : mem_ok) && qualify_s;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_r <= `CMD_IDLE;
      ale_r <= 1'b0;
      den_r <= 1'b0;
      dir_r <= 1'b0;
      shared_r <= 1'b0;
      mem_oe_r <= 1'b0;
      io_oe_r <= 1'b0;
    end else begin
      cmd_r <= cmd_nxt;
      ale_r <= ale_nxt;
      den_r <= den_nxt;
      dir_r <= dir_nxt;
      shared_r <= shared_nxt;
      mem_oe_r <= mem_oe_nxt;
      io_oe_r <= io_oe_nxt;
    end
  end

  // ==========================================
  // Outputs
  // Strobes drive their inactive level even when not qualified
  assign cmd_n = cmd_r;
  assign addr_latch_strobe = ale_r;
  assign data_xcvr_enable = den_r;
  assign xfer_direction = dir_r;
  assign cascade_periph_xcvr_enable_n = shared_r;
  // A raw grant release floats the gated drivers with no clock edge
  assign mem_cmd_oe = mem_oe_r && !bus_grant_n;
  assign io_cmd_oe = io_oe_r && (io_mode_r || !bus_grant_n);

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence cycle_start;
    phase_r == PH_IDLE && !passive_s;
  endsequence

  sequence ale_one_shot;
    ale_r ##1 !ale_r;
  endsequence

  quiet_when_idle_a: assert property (
    phase_r == PH_IDLE |-> cmd_n == `CMD_IDLE && !data_xcvr_enable)
    else $error("strobe active with no cycle");

  ale_pulse_a: assert property (
    cycle_start |=> ale_one_shot)
    else $error("address strobe not a single pulse");

  write_direction_a: assert property (
    phase_r == PH_CMD && (code_r == ST_IO_WRITE || code_r == ST_MEM_WRITE)
    |-> xfer_direction)
    else $error("direction low on a write");

  read_direction_a: assert property (
    phase_r == PH_CMD && (code_r == ST_INT_ACK || code_r == ST_MEM_READ)
    |-> !xfer_direction)
    else $error("direction high on a read");

  qualify_off_a: assert property (
    !qualify_s |=> cmd_n == `CMD_IDLE && !data_xcvr_enable
      && (!io_mode_r || cascade_periph_xcvr_enable_n))
    else $error("command active without qualifier");

  grant_float_a: assert property (
    bus_grant_n && !io_mode_r |-> !io_cmd_oe && !mem_cmd_oe)
    else $error("drivers on without grant");

  io_free_a: assert property (
    io_mode_r && io_mode_nxt |=> io_cmd_oe)
    else $error("I/O drivers gated in I/O mode");

  mem_wait_a: assert property (
    !grant_ready |=> cmd_n.mem_read_n && cmd_n.mem_write_n
      && cmd_n.early_mem_write_n)
    else $error("memory command before grant");

  early_io_a: assert property (
    phase_r == PH_ADDR && code_r == ST_IO_WRITE && io_ok && !passive_s
    |=> !cmd_n.early_io_write_n && cmd_n.io_write_n)
    else $error("early write not ahead of write");

  int_ack_a: assert property (
    phase_r == PH_ADDR && code_r == ST_INT_ACK && io_ok && !passive_s
    |=> !cmd_n.int_ack_n)
    else $error("acknowledge strobe missing");

  end_on_passive_a: assert property (
    phase_r != PH_IDLE && passive_s |=> cmd_n == `CMD_IDLE)
    else $error("command kept after passive");

  // Normal memory write joins the early write one cycle later
  late_write_a: assert property (
    phase_r == PH_CMD && code_r == ST_MEM_WRITE && mem_ok && !passive_s
    |=> !cmd_n.mem_write_n && !cmd_n.early_mem_write_n)
    else $error("memory write not following early write");

  // System bus mode holds every I/O strobe until the grant is ready
  io_wait_a: assert property (
    !io_mode_nxt && !grant_ready |=> cmd_n.io_read_n && cmd_n.io_write_n
      && cmd_n.early_io_write_n && cmd_n.int_ack_n)
    else $error("I/O command before grant in system bus mode");

  // Memory reads open the data transceiver with the strobe
  den_mem_a: assert property (
    phase_r == PH_ADDR && code_r == ST_MEM_READ && mem_ok && !passive_s
    |=> data_xcvr_enable && !cmd_n.mem_read_n)
    else $error("transceiver off during memory read");

  // I/O bus cycles use the peripheral enable instead of the data enable
  periph_xcvr_enable_n_io_a: assert property (
    io_mode_nxt && phase_r == PH_ADDR && io_cycle && io_ok && !passive_s
    |=> !cascade_periph_xcvr_enable_n && !data_xcvr_enable)
    else $error("peripheral enable missing on I/O cycle");

  // Cascade strobe rides with the address strobe of an acknowledge cycle
  mce_strobe_a: assert property (
    phase_r == PH_IDLE && status_s == ST_INT_ACK |=> cascade_periph_xcvr_enable_n)
    else $error("cascade strobe missing on acknowledge");

endmodule : status_bus_command_decoder

//--- tb/cpu_arb_model.sv
// Processor status source and bus arbiter model
`timescale 1ns/10ps
module cpu_arb_model
  import cmd_decoder_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire status_t code,
  input wire logic bus_free,
  output logic status_bit_zero_n,
  output logic status_bit_one_n,
  output logic status_bit_two_n,
  output logic bus_grant_n,
  output logic busy
);
  logic [3:0] left_r;
  // =========================================
  // Status code held for a fixed span, passive otherwise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {status_bit_two_n, status_bit_one_n, status_bit_zero_n} <= ST_PASSIVE;
      left_r <= 4'h0;
    end else if (start) begin
      {status_bit_two_n, status_bit_one_n, status_bit_zero_n} <= code;
      left_r <= 4'h8;
    end else if (left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
      if (left_r == 4'h1) begin
        {status_bit_two_n, status_bit_one_n, status_bit_zero_n} <= ST_PASSIVE;
      end
    end
  end
  // Grant only while the shared bus is free, registered one clock after bus_free
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_grant_n <= 1'b1;
    end else begin
      bus_grant_n <= !bus_free;
    end
  end
  assign busy = start || (left_r != 4'h0);
endmodule : cpu_arb_model

//--- tb/test_status_bus_command_decoder.sv
// Self-checking bench of the status bus command decoder
`timescale 1ns/10ps
`include "cmd_decoder_regs.svh"
module test_status_bus_command_decoder;
  import cmd_decoder_pkg::*;
  logic clk, resetn, start, bus_free, cmd_qualify, io_bus_strap;
  logic s0_n, s1_n, s2_n, bus_grant_n, busy;
  status_t code;
  cmd_t cmd_n;
  logic mem_cmd_oe, io_cmd_oe, addr_latch_strobe, data_xcvr_enable;
  logic xfer_direction, cascade_periph_xcvr_enable_n;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  status_bus_command_decoder #(.GRANT_CYCLES(`GRANT_DELAY_CYC))
    status_bus_command_decoder_inst (
    .clk(clk), .resetn(resetn), .status_bit_zero_n(s0_n), .status_bit_one_n(s1_n),
    .status_bit_two_n(s2_n), .bus_grant_n(bus_grant_n), .cmd_qualify(cmd_qualify),
    .io_bus_strap(io_bus_strap), .cmd_n(cmd_n), .mem_cmd_oe(mem_cmd_oe),
    .io_cmd_oe(io_cmd_oe), .addr_latch_strobe(addr_latch_strobe),
    .data_xcvr_enable(data_xcvr_enable), .xfer_direction(xfer_direction),
    .cascade_periph_xcvr_enable_n(cascade_periph_xcvr_enable_n));
  cpu_arb_model cpu_arb_model_inst (
    .clk(clk), .resetn(resetn), .start(start), .code(code), .bus_free(bus_free),
    .status_bit_zero_n(s0_n), .status_bit_one_n(s1_n), .status_bit_two_n(s2_n),
    .bus_grant_n(bus_grant_n), .busy(busy));
  // =========================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [6:0] ex, input logic [6:0] got);
    checks_done++;
    if (got !== ex) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // =========================================
  // One machine cycle with expectations worked out from mode and grant
  task automatic do_cycle(input status_t c, input logic io, input logic g, input logic q);
    logic mem, ioc, act;
    logic [6:0] e;
    int n;
    mem = c[2] && (c != ST_PASSIVE);
    ioc = !c[2] && (c != ST_HALT);
    act = q && ((mem && g) || (ioc && (g || io)));
    case (c)
      ST_INT_ACK: e = 7'h7e;
      ST_IO_READ: e = 7'h77;
      ST_IO_WRITE: e = 7'h79;
      ST_CODE, ST_MEM_READ: e = 7'h3f;
      ST_MEM_WRITE: e = 7'h4f;
      default: e = 7'h7f;
    endcase
    if (!act) e = 7'h7f;
    @(posedge clk);
    code <= c;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    @(negedge clk);
    while (addr_latch_strobe !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk("ale", c != ST_PASSIVE, addr_latch_strobe);
    chk("dir", (c == ST_IO_WRITE) || (c == ST_MEM_WRITE), xfer_direction);
    if (!io && q) chk("mce", c == ST_INT_ACK, cascade_periph_xcvr_enable_n);
    @(negedge clk);
    chk("ale_fall", 7'h0, addr_latch_strobe);
    @(negedge clk);
    chk("cmd", e, cmd_n);
    chk("mem_oe", g, mem_cmd_oe);
    chk("io_oe", g || io, io_cmd_oe);
    chk("den", act && !(io && ioc), data_xcvr_enable);
    if (io) chk("periph_xcvr_enable_n", !(act && ioc), cascade_periph_xcvr_enable_n);
    n = 0;
    while (busy && n < 16) begin
      @(negedge clk);
      n++;
    end
    repeat (4) @(negedge clk);
    chk("end", 7'h7f, cmd_n);
  endtask : do_cycle
  task automatic set_mode(input logic io, input logic g);
    @(posedge clk);
    io_bus_strap <= io;
    bus_free <= g;
    repeat (10) @(posedge clk);
  endtask : set_mode
  task automatic all_codes(input logic io, input logic g, input logic q);
    for (int i = 0; i < 8; i++) begin
      do_cycle(status_t'(i), io, g, q);
    end
  endtask : all_codes
  // =========================================
  // Scenarios
  task automatic scen_grant();
    set_mode(1'b1, 1'b0);
    bus_free <= 1'b1;
    // Arbiter flop, two sync stages, the grant count and the enable flop
    repeat (`GRANT_DELAY_CYC + 4) @(negedge clk);
    chk("oe_early", 7'h0, mem_cmd_oe);
    @(negedge clk);
    chk("oe_late", 7'h1, mem_cmd_oe);
    @(posedge clk);
    bus_free <= 1'b0;
    @(posedge clk);
    #1;
    chk("oe_float", 7'h0, mem_cmd_oe);
    chk("io_oe_kept", 7'h1, io_cmd_oe);
  endtask : scen_grant
  task automatic scen_sys();
    set_mode(1'b0, 1'b1);
    all_codes(1'b0, 1'b1, 1'b1);
  endtask : scen_sys
  task automatic scen_io();
    set_mode(1'b1, 1'b1);
    all_codes(1'b1, 1'b1, 1'b1);
  endtask : scen_io
  task automatic scen_nogrant();
    set_mode(1'b1, 1'b0);
    all_codes(1'b1, 1'b0, 1'b1);
    set_mode(1'b0, 1'b0);
    all_codes(1'b0, 1'b0, 1'b1);
  endtask : scen_nogrant
  task automatic scen_qual();
    set_mode(1'b1, 1'b1);
    cmd_qualify <= 1'b0;
    all_codes(1'b1, 1'b1, 1'b0);
    set_mode(1'b0, 1'b1);
    all_codes(1'b0, 1'b1, 1'b0);
    @(posedge clk);
    cmd_qualify <= 1'b1;
  endtask : scen_qual
  // =========================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    start = 1'b0;
    bus_free = 1'b0;
    cmd_qualify = 1'b1;
    io_bus_strap = 1'b0;
    code = ST_PASSIVE;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(negedge clk);
    chk("rst_cmd", 7'h7f, cmd_n);
    scen_grant();
    scen_sys();
    scen_io();
    scen_nogrant();
    scen_qual();
    complete_run();
  end
endmodule : test_status_bus_command_decoder
